// ### pldcel_pkg.sv
`default_nettype none

package pldcel_pkg;

	// ---------------------------------------------------------------
	// array sizes and input bus layout
	// ---------------------------------------------------------------
	localparam int NBUS      = 73;
	localparam int NDT       = 42;
	localparam int NGT       = 137;
	localparam int NCELL     = 16;
	localparam int NICELL    = 24;
	localparam int B_ADDR    = 0;
	localparam int B_CTRL    = 16;
	localparam int B_RST     = 19;
	localparam int B_PDN     = 20;
	localparam int B_ICELL   = 21;
	localparam int B_PORTD   = 45;
	localparam int B_PAGE    = 48;
	localparam int B_FB      = 56;
	localparam int B_RDY     = 72;

	// ---------------------------------------------------------------
	// decode term layout and general term allocation
	// ---------------------------------------------------------------
	localparam int DT_MAIN   = 0;
	localparam int DT_BOOT   = 24;
	localparam int DT_SRAM   = 36;
	localparam int DT_CFG    = 38;
	localparam int DT_TEST   = 39;
	localparam int DT_PERI   = 40;
	localparam int NAT_AB    = 3;
	localparam int NAT_BC    = 4;
	localparam int NAT_TOTAL = 56;
	localparam int BOR_AB    = 6;
	localparam int BOR_BC_LO = 5;
	localparam int BOR_BC_HI = 6;
	localparam logic [4:0] OWN_ECS  = 5'h10;
	localparam logic [7:0] TERM_NONE = 8'hff;

	// ---------------------------------------------------------------
	// register map, fields, reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] A_PMR0    = 8'h00;
	localparam logic [7:0] A_PMR2    = 8'h04;
	localparam logic [7:0] A_PAGE    = 8'h08;
	localparam logic [7:0] A_MASK_AB = 8'h0c;
	localparam logic [7:0] A_MASK_BC = 8'h10;
	localparam logic [7:0] A_CELL_AB = 8'h14;
	localparam logic [7:0] A_CELL_BC = 8'h18;
	localparam logic [7:0] A_ICELL   = 8'h1c;
	localparam logic [7:0] A_STATUS  = 8'h20;
	localparam int         PMR0_FAST = 3;
	localparam logic [7:0] RST_PMR0  = 8'h00;
	localparam logic [7:0] RST_PMR2  = 8'h00;
	localparam logic [7:0] RST_MASK  = 8'h00;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_NS    = 100;
	localparam int IDLE_NS   = 70;
	localparam int IDLE_RAW  = (IDLE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] IDLE_CYC = 4'((IDLE_RAW < 1) ? 1 : IDLE_RAW);

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} pldcel_ff_kind_t;

	typedef struct packed {
		logic            pol;
		logic            comb;
		pldcel_ff_kind_t kind;
		logic            clk_pin;
		logic [7:0]      clk_term;
		logic [7:0]      pre_term;
		logic [7:0]      clr_term0;
		logic [7:0]      clr_term1;
		logic [7:0]      k_term;
	} pldcel_cell_cfg_t;

	typedef struct packed {
		logic [19:0] addr;
		logic [2:0]  ctrl;
		logic        rst;
		logic        power_down_input;
		logic [23:0] port_in;
		logic [2:0]  port_d;
		logic        rdy_busy;
		logic        lclk;
	} pldcel_pins_t;

	typedef struct packed {
		logic [7:0] main_fs;
		logic [3:0] boot_fs;
		logic       sram;
		logic       cfg_space;
		logic       test_port;
		logic [1:0] periph;
	} pldcel_dec_sel_t;

endpackage

`default_nettype wire

// ### pldcel_top.sv
`default_nettype none

module pldcel_top (
	input  wire logic                                   mclk_i,
	input  wire logic                                   resetn_i,
	input  wire logic                                   wb_cyc_i,
	input  wire logic                                   wb_stb_i,
	input  wire logic                                   wb_we_i,
	input  wire logic [7:0]                             wb_adr_i,
	input  wire logic [3:0]                             wb_sel_i,
	input  wire logic [31:0]                            wb_dat_i,
	output logic      [31:0]                            wb_dat_o,
	output logic                                        wb_ack_o,
	input  wire pldcel_pkg::pldcel_pins_t               pins_i,
	input  wire logic                                   cfg_done_i,
	input  wire logic                                   cfg_wide_addr_i,
	input  wire logic                                   cfg_load_level_i,
	input  wire logic [pldcel_pkg::NDT-1:0][2*pldcel_pkg::NBUS-1:0] cfg_dec_plane_i,
	input  wire logic [pldcel_pkg::NGT-1:0][2*pldcel_pkg::NBUS-1:0] cfg_gen_plane_i,
	input  wire logic [pldcel_pkg::NGT-1:0][4:0]        cfg_owner_i,
	input  wire pldcel_pkg::pldcel_cell_cfg_t [pldcel_pkg::NCELL-1:0] cfg_cell_i,
	output pldcel_pkg::pldcel_dec_sel_t                 dec_sel_o,
	output logic      [2:0]                             ext_cs_o,
	output logic      [pldcel_pkg::NCELL-1:0]           cell_out_o
);

	localparam int NB = pldcel_pkg::NBUS;
	localparam int NG = pldcel_pkg::NGT;
	localparam int NC = pldcel_pkg::NCELL;

	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	// product term: and of selected true and complement inputs; an empty term is off
	function automatic logic pterm(input logic [NB-1:0] b, input logic [2*NB-1:0] m);
		pterm = (|m) & (&((~m[NB-1:0] | b) & (~m[2*NB-1:NB] | ~b)));
	endfunction

	// pick one general term by index; out-of-range index means unused
	function automatic logic pick(input logic [NG-1:0] t, input logic [7:0] idx);
		pick = (idx < 8'(NG)) ? t[idx] : 1'b0;
	endfunction

	// terms owned by one cell: native ones fixed, the rest by owner code
	function automatic logic [NG-1:0] own_mask(input logic [NG-1:0][4:0] o,
			input logic [4:0] code);
		logic [4:0] nat;
		own_mask = '0;
		for (int t = 0; t < NG; t++) begin
			nat = (t < 24) ? 5'(t / 3) : 5'(8 + (t - 24) / 4);
			own_mask[t] = (t < pldcel_pkg::NAT_TOTAL) ? (nat == code) : (o[t] == code);
		end
	endfunction

	// next state of a cell flop; s is the sum, k the second term for JK and SR
	function automatic logic ff_step(input pldcel_pkg::pldcel_ff_kind_t kind,
			input logic q, input logic s, input logic k);
		case (kind)
			pldcel_pkg::FF_D:  ff_step = s;
			pldcel_pkg::FF_T:  ff_step = q ^ s;
			pldcel_pkg::FF_JK: ff_step = (s & ~q) | (~k & q);
			pldcel_pkg::FF_SR: ff_step = s | (q & ~k);
			default:           ff_step = q;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	pldcel_pkg::pldcel_pins_t pin_m;
	pldcel_pkg::pldcel_pins_t pin_s;
	logic                     done_m;
	logic                     done_s;
	logic                     lclk_prev;

	// two flops on every pin and on the configuration-done level
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_m     <= '0;
			pin_s     <= '0;
			done_m    <= 1'b0;
			done_s    <= 1'b0;
			lclk_prev <= 1'b0;
		end else begin
			pin_m     <= pins_i;
			pin_s     <= pin_m;
			done_m    <= cfg_done_i;
			done_s    <= done_m;
			lclk_prev <= pin_s.lclk;
		end
	end

	wire lclk_rise = pin_s.lclk & ~lclk_prev;

	// ---------------------------------------------------------------
	// registers and wishbone slave
	// ---------------------------------------------------------------
	logic [7:0]    pmr0;
	logic [7:0]    pmr2;
	logic [7:0]    page;
	logic [7:0]    mask_ab;
	logic [7:0]    mask_bc;
	logic [NC-1:0] ff;
	logic          standby;

	wire       req     = wb_cyc_i & wb_stb_i;
	wire       wr_fire = req & wb_we_i & wb_ack_o;
	wire       wr_b0   = wr_fire & wb_sel_i[0];
	// level loading acts in the request's first cycle, edge loading at its end
	wire       ld_strb = (cfg_load_level_i ? (req & wb_we_i & ~wb_ack_o) : wr_fire)
		& wb_sel_i[0];
	wire [7:0] ld_ab   = {8{ld_strb & (wb_adr_i == pldcel_pkg::A_CELL_AB)}} & ~mask_ab;
	wire [7:0] ld_bc   = {8{ld_strb & (wb_adr_i == pldcel_pkg::A_CELL_BC)}} & ~mask_bc;
	wire [NC-1:0] ld_cell = {ld_bc, ld_ab};

	// read selection; unmapped offsets read zero and still acknowledge
	wire [31:0] rd_data =
		(wb_adr_i == pldcel_pkg::A_PMR0)    ? {24'h000000, pmr0} :
		(wb_adr_i == pldcel_pkg::A_PMR2)    ? {24'h000000, pmr2} :
		(wb_adr_i == pldcel_pkg::A_PAGE)    ? {24'h000000, page} :
		(wb_adr_i == pldcel_pkg::A_MASK_AB) ? {24'h000000, mask_ab} :
		(wb_adr_i == pldcel_pkg::A_MASK_BC) ? {24'h000000, mask_bc} :
		(wb_adr_i == pldcel_pkg::A_CELL_AB) ? {24'h000000, ff[7:0]} :
		(wb_adr_i == pldcel_pkg::A_CELL_BC) ? {24'h000000, ff[15:8]} :
		(wb_adr_i == pldcel_pkg::A_ICELL)   ? {8'h00, pin_s.port_in} :
		(wb_adr_i == pldcel_pkg::A_STATUS)  ? {30'h00000000, done_s, standby} :
		32'h00000000;

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			wb_dat_o <= (req & ~wb_ack_o) ? rd_data : 32'h00000000;
		end
	end

	// writable registers take byte lane 0 on the acknowledged cycle
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pmr0    <= pldcel_pkg::RST_PMR0;
			pmr2    <= pldcel_pkg::RST_PMR2;
			page    <= 8'h00;
			mask_ab <= pldcel_pkg::RST_MASK;
			mask_bc <= pldcel_pkg::RST_MASK;
		end else if (wr_b0) begin
			if (wb_adr_i == pldcel_pkg::A_PMR0)    pmr0    <= wb_dat_i[7:0];
			if (wb_adr_i == pldcel_pkg::A_PMR2)    pmr2    <= {3'h0, wb_dat_i[4:0]};
			if (wb_adr_i == pldcel_pkg::A_PAGE)    page    <= wb_dat_i[7:0];
			if (wb_adr_i == pldcel_pkg::A_MASK_AB) mask_ab <= wb_dat_i[7:0];
			if (wb_adr_i == pldcel_pkg::A_MASK_BC) mask_bc <= wb_dat_i[7:0];
		end
	end

	// ---------------------------------------------------------------
	// shared input bus
	// ---------------------------------------------------------------
	logic [NC-1:0] cell_q;

	wire [15:0] bus_addr = cfg_wide_addr_i ? pin_s.addr[19:4] : pin_s.addr[15:0];
	// blocked control lines read as inactive; only safe if no equation uses them
	wire [2:0]  bus_ctrl = pin_s.ctrl & ~pmr2[2:0];
	wire        bus_rst  = pin_s.rst & ~pmr2[3];
	wire        bus_pdn  = pin_s.power_down_input & ~pmr2[4];
	wire [NB-1:0] bus = {pin_s.rdy_busy, cell_q, page, pin_s.port_d, pin_s.port_in,
		bus_pdn, bus_rst, bus_ctrl, bus_addr};

	// ---------------------------------------------------------------
	// power: standby after the idle time when fast mode is off
	// ---------------------------------------------------------------
	logic [NB-1:0] bus_prev;
	logic [3:0]    idle_cnt;

	wire fast    = pmr0[pldcel_pkg::PMR0_FAST];
	wire changed = (bus != bus_prev);

	// waking costs one extra cycle of delay: that is the price of the power saving
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bus_prev <= '0;
			idle_cnt <= 4'h0;
			standby  <= 1'b0;
		end else begin
			bus_prev <= bus;
			idle_cnt <= changed ? 4'h0 : ((idle_cnt == 4'hf) ? idle_cnt : idle_cnt + 4'h1);
			standby  <= ~fast & ~changed & (idle_cnt >= pldcel_pkg::IDLE_CYC);
		end
	end

	// ---------------------------------------------------------------
	// AND planes
	// ---------------------------------------------------------------
	localparam int    NDT_W = pldcel_pkg::NDT;
	logic [NDT_W-1:0] dterm_q;
	logic [NG-1:0]    gterm_q;
	wire  [NDT_W-1:0] dterm_c;
	wire  [NG-1:0]    gterm_c;

	for (genvar t = 0; t < NDT_W; t++) begin : g_dterm
		assign dterm_c[t] = pterm(bus, cfg_dec_plane_i[t]);
	end
	for (genvar t = 0; t < NG; t++) begin : g_gterm
		assign gterm_c[t] = pterm(bus, cfg_gen_plane_i[t]);
	end

	// terms freeze while in standby
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dterm_q <= '0;
			gterm_q <= '0;
		end else if (!standby) begin
			dterm_q <= dterm_c;
			gterm_q <= gterm_c;
		end
	end

	// ---------------------------------------------------------------
	// decode selects
	// ---------------------------------------------------------------
	pldcel_pkg::pldcel_dec_sel_t dec_c;

	for (genvar k = 0; k < 8; k++) begin : g_main
		assign dec_c.main_fs[k] = |dterm_q[pldcel_pkg::DT_MAIN + 3*k +: 3];
	end
	for (genvar k = 0; k < 4; k++) begin : g_boot
		assign dec_c.boot_fs[k] = |dterm_q[pldcel_pkg::DT_BOOT + 3*k +: 3];
	end
	assign dec_c.sram      = |dterm_q[pldcel_pkg::DT_SRAM +: 2];
	assign dec_c.cfg_space = dterm_q[pldcel_pkg::DT_CFG];
	assign dec_c.test_port = dterm_q[pldcel_pkg::DT_TEST];
	assign dec_c.periph    = dterm_q[pldcel_pkg::DT_PERI +: 2];

	// ---------------------------------------------------------------
	// output cells
	// ---------------------------------------------------------------
	logic [NC-1:0] pt_clk_prev;
	wire  [NC-1:0] d_in;
	wire  [NC-1:0] next_ff;
	wire  [NC-1:0] cell_sel;
	wire  [NC-1:0] pt_clk;
	wire  [2:0]    ecs_c;

	for (genvar c = 0; c < NC; c++) begin : g_cell
		wire sum   = |(gterm_q & own_mask(cfg_owner_i, 5'(c)));
		wire k_in  = pick(gterm_q, cfg_cell_i[c].k_term);
		wire pre   = pick(gterm_q, cfg_cell_i[c].pre_term);
		wire clr   = pick(gterm_q, cfg_cell_i[c].clr_term0)
			| pick(gterm_q, cfg_cell_i[c].clr_term1);
		wire clk_e = cfg_cell_i[c].clk_pin ? lclk_rise
			: (pt_clk[c] & ~pt_clk_prev[c]);
		wire step  = ff_step(cfg_cell_i[c].kind, ff[c], d_in[c], k_in);
		assign pt_clk[c]   = pick(gterm_q, cfg_cell_i[c].clk_term);
		assign d_in[c]     = sum ^ cfg_cell_i[c].pol;
		// host load first, then clear, preset, clock
		assign next_ff[c]  = ld_cell[c] ? wb_dat_i[c % 8] :
			clr ? 1'b0 : pre ? 1'b1 : clk_e ? step : ff[c];
		assign cell_sel[c] = cfg_cell_i[c].comb ? d_in[c] : ff[c];
	end

	// external selects sit on their own owner codes, not on any cell
	for (genvar k = 0; k < 3; k++) begin : g_ecs
		assign ecs_c[k] = |(gterm_q & own_mask(cfg_owner_i, pldcel_pkg::OWN_ECS + 5'(k)));
	end

	// flops stay cleared until configuration is done
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ff          <= '0;
			pt_clk_prev <= '0;
		end else begin
			ff          <= done_s ? next_ff : '0;
			pt_clk_prev <= pt_clk;
		end
	end

	// registered outputs; the same value is the array feedback
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cell_q    <= '0;
			dec_sel_o <= '0;
			ext_cs_o  <= 3'h0;
		end else begin
			cell_q    <= done_s ? cell_sel : '0;
			dec_sel_o <= done_s ? dec_c : '0;
			ext_cs_o  <= done_s ? ecs_c : 3'h0;
		end
	end

	assign cell_out_o = cell_q;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	a_fast_awake: assert property (
		fast |=> !standby)
		else $error("standby entered with fast mode set");

	a_idle_sleep: assert property (
		!fast && !changed && idle_cnt >= pldcel_pkg::IDLE_CYC |=> standby)
		else $error("idle arrays did not enter standby");

	a_wake_change: assert property (
		standby && changed |=> !standby ##1 (gterm_q == $past(gterm_c)))
		else $error("standby not left after input change");

	a_ctrl_blocked: assert property (
		pmr2[0] |-> !bus[pldcel_pkg::B_CTRL])
		else $error("blocked control line reached the array");

	a_wide_addr: assert property (
		cfg_wide_addr_i |-> bus[15:0] == pin_s.addr[19:4])
		else $error("wide address mode takes wrong address bits");

	a_load_wins: assert property (
		done_s && ld_strb && wb_adr_i == pldcel_pkg::A_CELL_AB && !mask_ab[0]
		|=> ff[0] == $past(wb_dat_i[0]))
		else $error("host load did not override the cell flop");

	a_mask_blocks: assert property (
		done_s && mask_ab[1] && !g_cell[1].clr && !g_cell[1].pre && !g_cell[1].clk_e
		|=> ff[1] == $past(ff[1]))
		else $error("masked cell changed by host write");

	a_lclk_toggle: assert property (
		done_s && !ld_cell[2] && !g_cell[2].clr && !g_cell[2].pre && cfg_cell_i[2].clk_pin
		&& cfg_cell_i[2].kind == pldcel_pkg::FF_T && lclk_rise
		|=> ff[2] == ($past(ff[2]) ^ $past(d_in[2])))
		else $error("logic clock edge did not toggle T flop");

	a_cfg_gate: assert property (
		!done_s |=> cell_out_o == '0 && ext_cs_o == 3'h0 && dec_sel_o == '0)
		else $error("outputs active before configuration done");

	a_ack_pulse: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	c_standby: cover property (!standby ##1 standby ##[1:4] !standby);
	c_cell_load: cover property (ld_strb && |ld_ab);
	c_lclk_edge: cover property (done_s && lclk_rise);

endmodule // pldcel_top

`default_nettype wire

// ### pldcel_host_model.sv
`default_nettype none

// host and board side of the pins: address bus, port inputs, logic clock
module pldcel_host_model (
	input  wire logic              mclk_i,
	output var pldcel_pkg::pldcel_pins_t pins_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------
	// logic clock rests low between pulses so no stray flop clocking
	initial begin
		pins_o = '0;
	end

	task automatic set_addr(input logic [19:0] a);
		@(posedge mclk_i);
		pins_o.addr <= a;
	endtask

	task automatic set_port(input logic [23:0] p);
		@(posedge mclk_i);
		pins_o.port_in <= p;
	endtask

	task automatic set_ctrl(input logic [2:0] c);
		@(posedge mclk_i);
		pins_o.ctrl <= c;
	endtask

	// pulse held two cycles, long enough to cross the pin synchroniser
	task automatic clk_pulse();
		@(posedge mclk_i);
		pins_o.lclk <= 1'b1;
		repeat (2) @(posedge mclk_i);
		pins_o.lclk <= 1'b0;
	endtask
endmodule // pldcel_host_model

`default_nettype wire

// ### tb_programmable_decode_and_macrocells.sv
`default_nettype none

module tb_programmable_decode_and_macrocells;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------
	// signals and static configuration
	// ------------------------------------------------------------
	logic                        mclk_i, resetn_i, cyc, stb, we, done, wide, lvl;
	logic [7:0]                  adr;
	logic [3:0]                  sel;
	logic [31:0]                 wdat, rd, dat_o;
	logic                        ack;
	pldcel_pkg::pldcel_pins_t    pins;
	pldcel_pkg::pldcel_dec_sel_t dec;
	logic [2:0]                  ecs;
	logic [15:0]                 cout;
	logic [pldcel_pkg::NDT-1:0][2*pldcel_pkg::NBUS-1:0] dpl;
	logic [pldcel_pkg::NGT-1:0][2*pldcel_pkg::NBUS-1:0] gpl;
	logic [pldcel_pkg::NGT-1:0][4:0] own;
	pldcel_pkg::pldcel_cell_cfg_t [pldcel_pkg::NCELL-1:0] ccfg;
	int                          n_mismatch = 0;
	int                          cmp_count = 0;
	int                          cyc_n = 0;

	pldcel_host_model host (.mclk_i(mclk_i), .pins_o(pins));

	pldcel_top dut (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .pins_i(pins), .cfg_done_i(done),
		.cfg_wide_addr_i(wide), .cfg_load_level_i(lvl), .cfg_dec_plane_i(dpl),
		.cfg_gen_plane_i(gpl), .cfg_owner_i(own), .cfg_cell_i(ccfg),
		.dec_sel_o(dec), .ext_cs_o(ecs), .cell_out_o(cout));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	// one classic cycle; waits on ack, the global timeout cuts a hang
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge mclk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge mclk_i);
		end while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		wb(a, 1'b0, 32'h0);
		chk($sformatf("reg %h", a), rd, e);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// clock and timeout
	// ------------------------------------------------------------
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	// the whole sequence needs well under a thousand cycles
	always @(posedge mclk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 3000) begin
			n_mismatch++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		resetn_i = 1'b0;
		{cyc, stb, we, adr, wdat, wide, lvl} = '0;
		sel = 4'hf;
		done = 1'b1;
		dpl = '0;
		gpl = '0;
		own = {pldcel_pkg::NGT{5'h1f}};
		ccfg = '1;
		for (int c = 0; c < 16; c++) begin
			ccfg[c].pol = 1'b0;
			ccfg[c].comb = 1'b0;
			ccfg[c].clk_pin = 1'b0;
			ccfg[c].kind = pldcel_pkg::FF_D;
		end
		// cell 0: inverted combinational addr14; cell 2: T flop on logic clock
		ccfg[0].pol = 1'b1;
		ccfg[0].comb = 1'b1;
		ccfg[2].kind = pldcel_pkg::FF_T;
		ccfg[2].clk_pin = 1'b1;
		dpl[pldcel_pkg::DT_MAIN][15] = 1'b1;
		dpl[pldcel_pkg::DT_SRAM][pldcel_pkg::NBUS + 15] = 1'b1;
		dpl[pldcel_pkg::DT_CFG][pldcel_pkg::B_PAGE] = 1'b1;
		dpl[pldcel_pkg::DT_TEST][pldcel_pkg::B_CTRL] = 1'b1;
		gpl[0][14] = 1'b1;
		gpl[6][12] = 1'b1;
		gpl[56][13] = 1'b1;
		own[56] = pldcel_pkg::OWN_ECS;
		tick(3);
		resetn_i <= 1'b1;
		tick(4);
		rchk(pldcel_pkg::A_PMR0, 32'h0);
		rchk(pldcel_pkg::A_PMR2, 32'h0);
		rchk(pldcel_pkg::A_MASK_AB, 32'h0);
		rchk(pldcel_pkg::A_MASK_BC, 32'h0);
		rchk(8'h40, 32'h0);
		rchk(pldcel_pkg::A_STATUS, 32'h3);
		wb(pldcel_pkg::A_PMR0, 1'b1, 32'h8);
		rchk(pldcel_pkg::A_STATUS, 32'h2);
		$display("test reset_and_power done");
		host.set_addr(20'h08000);
		tick(6);
		chk("dec a", {15'h0, dec}, 32'h200);
		chk("ecs a", {29'h0, ecs}, 32'h0);
		chk("cell0 a", {31'h0, cout[0]}, 32'h1);
		host.set_addr(20'h07000);
		tick(6);
		chk("dec b", {15'h0, dec}, 32'h10);
		chk("ecs b", {29'h0, ecs}, 32'h1);
		chk("cell0 b", {31'h0, cout[0]}, 32'h0);
		wb(pldcel_pkg::A_PAGE, 1'b1, 32'h1);
		rchk(pldcel_pkg::A_PAGE, 32'h1);
		tick(5);
		chk("dec page", {15'h0, dec}, 32'h18);
		$display("test decode done");
		host.set_port(24'h123456);
		tick(4);
		rchk(pldcel_pkg::A_ICELL, 32'h123456);
		wb(pldcel_pkg::A_CELL_AB, 1'b1, 32'hfe);
		rchk(pldcel_pkg::A_CELL_AB, 32'hfe);
		tick(2);
		chk("cells ab", {24'h0, cout[7:0]}, 32'hfe);
		wb(pldcel_pkg::A_MASK_AB, 1'b1, 32'h0f);
		rchk(pldcel_pkg::A_MASK_AB, 32'h0f);
		wb(pldcel_pkg::A_CELL_AB, 1'b1, 32'h0);
		rchk(pldcel_pkg::A_CELL_AB, 32'h0e);
		wb(pldcel_pkg::A_CELL_BC, 1'b1, 32'h5a);
		rchk(pldcel_pkg::A_CELL_BC, 32'h5a);
		tick(2);
		chk("cells bc", {24'h0, cout[15:8]}, 32'h5a);
		host.clk_pulse();
		tick(6);
		rchk(pldcel_pkg::A_CELL_AB, 32'h0a);
		$display("test cells done");
		host.set_ctrl(3'h1);
		tick(6);
		chk("dec ctrl", {15'h0, dec}, 32'h1c);
		wb(pldcel_pkg::A_PMR2, 1'b1, 32'h1f);
		rchk(pldcel_pkg::A_PMR2, 32'h1f);
		wb(pldcel_pkg::A_PMR0, 1'b1, 32'h0);
		tick(3);
		rchk(pldcel_pkg::A_STATUS, 32'h3);
		host.set_addr(20'h08000);
		tick(7);
		chk("dec wake", {15'h0, dec}, 32'h208);
		$display("test standby done");
		wide <= 1'b1;
		host.set_addr(20'h80000);
		tick(7);
		chk("dec wide", {15'h0, dec}, 32'h208);
		lvl <= 1'b1;
		wb(pldcel_pkg::A_CELL_BC, 1'b1, 32'ha5);
		rchk(pldcel_pkg::A_CELL_BC, 32'ha5);
		sel <= 4'he;
		wb(pldcel_pkg::A_CELL_BC, 1'b1, 32'h00);
		sel <= 4'hf;
		rchk(pldcel_pkg::A_CELL_BC, 32'ha5);
		$display("test modes done");
		resetn_i <= 1'b0;
		done <= 1'b0;
		tick(2);
		resetn_i <= 1'b1;
		tick(4);
		chk("dec rst", {15'h0, dec}, 32'h0);
		chk("outs rst", {13'h0, ecs, cout}, 32'h0);
		rchk(pldcel_pkg::A_MASK_AB, 32'h0);
		rchk(pldcel_pkg::A_STATUS, 32'h1);
		done <= 1'b1;
		tick(8);
		chk("dec cfg", {15'h0, dec}, 32'h204);
		$display("test reset_and_config done");
		stop_test();
	end
endmodule // tb_programmable_decode_and_macrocells

`default_nettype wire
